/* bench/hls_asserts.sv */
module hls_asserts #(
    parameter int BIT_CYC_DEF = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial line
    input wire logic line_rx,
    input wire logic line_tx,
    input wire logic line_tx_oe,
    // configuration
    input wire logic [7:0] reply_dwell,
    input wire logic [3:0] startup_mode_setting,
    input wire logic [15:0] line_rate_setting,
    input wire logic [7:0] reply_format_options,
    input wire logic [15:0] alarm_cond,
    // status
    input wire logic [15:0] alarm_word_q,
    input wire logic motor_disable_q,
    input wire logic status_fault_q,
    input wire logic text_mode_q,
    input wire logic comm_err_led_q,
    input wire logic saved_rate_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // length of a driven mark run
    logic [15:0] hi_run_q;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            hi_run_q <= 16'h0;
        else if (line_tx_oe && line_tx)
            hi_run_q <= hi_run_q + 16'h1;
        else
            hi_run_q <= 16'h0;
    a_rsvd_zero: assert property (alarm_word_q[15] == 1'b0 && alarm_word_q[13] == 1'b0
        && alarm_word_q[9] == 1'b0) else $error("reserved alarm bit set");
    a_alarm_follow: assert property ($past(rst_n) |->
        (alarm_word_q & 16'h59ff) == ($past(alarm_cond) & 16'h59ff)) else $error("alarm word lag");
    a_fault_disable: assert property ($past(rst_n) |->
        motor_disable_q == |($past(alarm_word_q) & 16'h01b9)) else $error("motor disable wrong");
    a_fault_status: assert property (status_fault_q == motor_disable_q)
        else $error("fault bit differs");
    a_oe_idle: assert property (!line_tx_oe |-> line_tx) else $error("line low while released");
    a_oe_lead: assert property ($rose(line_tx_oe) |-> ##[0:3] !line_tx)
        else $error("driver on without start bit");
    a_oe_release: assert property (int'(hi_run_q) <
        10 * (saved_rate_q ? int'(line_rate_setting) : BIT_CYC_DEF) + 8)
        else $error("driver held after packet");
    a_text_hold: assert property ($past(text_mode_q) |-> text_mode_q) else $error("text mode lost");
    a_rate_hold: assert property ($past(saved_rate_q) |-> saved_rate_q) else $error("rate lost");
    a_tool_keep: assert property ($rose(saved_rate_q) |-> text_mode_q ==
        !(startup_mode_setting == 4'h1 || startup_mode_setting == 4'h3)) else $error("mode wrong");
endmodule

bind hls_top hls_asserts #(.BIT_CYC_DEF(BIT_CYC_DEF)) u_asserts (.core_clk(core_clk),
    .rst_n(rst_n), .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe),
    .reply_dwell(reply_dwell), .startup_mode_setting(startup_mode_setting),
    .line_rate_setting(line_rate_setting), .reply_format_options(reply_format_options),
    .alarm_cond(alarm_cond), .alarm_word_q(alarm_word_q), .motor_disable_q(motor_disable_q),
    .status_fault_q(status_fault_q), .text_mode_q(text_mode_q),
    .comm_err_led_q(comm_err_led_q), .saved_rate_q(saved_rate_q));

/* bench/hls_host_model.sv */
module hls_host_model (
    // clock
    input wire logic core_clk,
    // bit period in clock cycles
    input wire logic [15:0] bit_cyc,
    // device serial lines
    input wire logic line_tx,
    input wire logic line_tx_oe,
    output logic line_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rxq[$];
    // idle mark between frames
    initial line_rx = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            line_rx <= f[i];
            repeat (bit_cyc - 1) @(posedge core_clk);
        end
    endtask
    // sample each device character mid bit
    always
    begin
        logic [7:0] d;
        @(posedge core_clk iff (line_tx_oe && !line_tx));
        repeat (bit_cyc / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_cyc) @(posedge core_clk);
            d[i] = line_tx;
        end
        repeat (bit_cyc) @(posedge core_clk);
        rxq.push_back(d);
    end
endmodule

/* bench/tb.sv */
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 20;
    logic core_clk, rst_n, line_rx, line_tx, line_tx_oe, motor_disable_q, status_fault_q;
    logic text_mode_q, comm_err_led_q, saved_rate_q;
    logic [7:0] reply_dwell, reply_format_options;
    logic [3:0] startup_mode_setting;
    logic [15:0] line_rate_setting, alarm_cond, alarm_word_q, bit_cyc;
    logic [31:0] seed;
    int bad_count, checks_done, t;
    hls_top #(.BIT_CYC_DEF(16), .MS_CYC(MS)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe),
        .reply_dwell(reply_dwell), .startup_mode_setting(startup_mode_setting),
        .line_rate_setting(line_rate_setting), .reply_format_options(reply_format_options),
        .alarm_cond(alarm_cond), .alarm_word_q(alarm_word_q), .motor_disable_q(motor_disable_q),
        .status_fault_q(status_fault_q), .text_mode_q(text_mode_q),
        .comm_err_led_q(comm_err_led_q), .saved_rate_q(saved_rate_q));
    hls_host_model u_host (.core_clk(core_clk), .bit_cyc(bit_cyc), .line_tx(line_tx),
        .line_tx_oe(line_tx_oe), .line_rx(line_rx));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_reply(input logic [7:0] e[$]);
        t = 0;
        while (u_host.rxq.size() < e.size() && t < 20000)
        begin
            @(posedge core_clk);
            t++;
        end
        if (t == 20000)
        begin
            bad_count++;
            print_verdict();
        end
        foreach (e[i]) `CHK("reply byte", e[i], u_host.rxq[i]);
        repeat (200) @(posedge core_clk);
        `CHK("reply count", e.size(), u_host.rxq.size());
        u_host.rxq.delete();
    endtask
    task automatic send_cmd(input logic [7:0] a, input logic [7:0] b);
        repeat (32) @(posedge core_clk);
        u_host.send_byte(a);
        u_host.send_byte(b);
        u_host.send_byte(8'h0d);
    endtask
    task automatic al_query(input logic [15:0] cond);
        logic [7:0] e[$];
        logic [15:0] w;
        logic [3:0] n;
        bit lead;
        w = cond & 16'h59ff;
        alarm_cond <= cond;
        repeat (3) @(posedge core_clk);
        `CHK("alarm_word", w, alarm_word_q);
        `CHK("motor_disable", |(w & 16'h01b9), motor_disable_q);
        send_cmd(8'h41, 8'h4c);
        e = '{8'h41, 8'h4c, 8'h3d};
        lead = 1;
        for (int i = 3; i >= 0; i--)
        begin
            n = w[i*4 +: 4];
            if (n != 4'h0 || i == 0)
                lead = 0;
            if (!lead)
                e.push_back(n < 10 ? 8'h30 + 8'(n) : 8'h37 + 8'(n));
        end
        e.push_back(8'h0d);
        check_reply(e);
    endtask
    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        {rst_n, alarm_cond, reply_format_options, bad_count, checks_done} = '0;
        bit_cyc = 16'd16;
        line_rate_setting = 16'd24;
        startup_mode_setting = 4'h1;
        reply_dwell = 8'h01;
        seed = 32'h91ad;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        check_reply('{8'hff, 8'h11, 8'h22});
        repeat (3 * MS) @(posedge core_clk);
        u_host.send_byte(8'h30);
        u_host.send_byte(8'h30);
        repeat (40) @(posedge core_clk);
        `CHK("text_mode", 1'b1, text_mode_q);
        `CHK("saved_rate", 1'b0, saved_rate_q);
        al_query(16'h0044);
        al_query(16'hffff);
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            al_query(seed[15:0]);
        end
        send_cmd(8'h58, 8'h58);
        check_reply('{});
        reply_format_options <= 8'h04;
        send_cmd(8'h58, 8'h58);
        check_reply('{8'h3f, 8'h0d});
        u_host.line_rx <= 1'b0;
        repeat (158) @(posedge core_clk);
        u_host.line_rx <= 1'b1;
        `CHK("comm_err_led", 1'b1, comm_err_led_q);
        `CHK("comm_alarm", 1'b1, alarm_word_q[10]);
        send_cmd(8'h43, 8'h45);
        check_reply('{8'h43, 8'h45, 8'h3d, 8'h31, 8'h0d});
        `CHK("comm_err_led", 1'b0, comm_err_led_q);
        rst_n <= 1'b0;
        startup_mode_setting <= 4'h3;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        check_reply('{8'hff, 8'h11, 8'h22});
        t = 0;
        while (saved_rate_q !== 1'b1 && t < 50000)
        begin
            @(posedge core_clk);
            t++;
        end
        `CHK("saved_rate", 1'b1, saved_rate_q);
        `CHK("text_mode", 1'b0, text_mode_q);
        bit_cyc = 16'd24;
        send_cmd(8'h41, 8'h4c);
        check_reply('{});
        print_verdict();
    end
endmodule

/* core/hls_consts.vh */
`ifndef HLS_CONSTS_VH
`define HLS_CONSTS_VH

// timebase
`define HLS_CLK_HZ 100000000
`define HLS_DEF_BAUD 9600
`define HLS_BIT_CYC (`HLS_CLK_HZ / `HLS_DEF_BAUD)
`define HLS_MS_CYC (`HLS_CLK_HZ / 1000)

// timing figures in milliseconds
`define HLS_ANN_WAIT_MS 11'd2000
`define HLS_CHAR_TO_MS 11'd200

// transmitter release delay, microseconds; not used, line_tx_oe drops one cycle after the last stop bit
`define HLS_RELEASE_US 100

// character codes
`define HLS_CH_ANN 8'hff
`define HLS_CH_CR 8'h0d
`define HLS_CH_ZERO 8'h30
`define HLS_CH_A 8'h41
`define HLS_CH_L 8'h4c
`define HLS_CH_C 8'h43
`define HLS_CH_E 8'h45
`define HLS_CH_EQ 8'h3d
`define HLS_CH_ERR 8'h3f

// alarm word layout
`define HLS_AL_RSVD_MASK 16'ha200
`define HLS_AL_FAULT_MASK 16'h01b9
`define HLS_AL_COMM_BIT 10

// reply-format option bit enabling parse error replies
`define HLS_FMT_ERR_BIT 2

// startup modes that keep the configuration-tool protocol
`define HLS_PM_TOOL_A 4'h1
`define HLS_PM_TOOL_B 4'h3

// communication error causes
`define HLS_CE_NONE 4'h0
`define HLS_CE_FRAME 4'h1
`define HLS_CE_OVERRUN 4'h2

// reply kinds
`define HLS_K_ANN 2'h0
`define HLS_K_AL 2'h1
`define HLS_K_CE 2'h2
`define HLS_K_ERR 2'h3

`endif

/* core/hls_top.v */
`include "hls_consts.vh"

module hls_top #(
    parameter BIT_CYC_DEF = `HLS_BIT_CYC,
    parameter MS_CYC = `HLS_MS_CYC,
    // arbitrary identification values
    parameter [7:0] FW_VERSION = 8'h11,
    parameter [7:0] MODEL_CODE = 8'h22
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // shared serial line
    input wire line_rx,
    output wire line_tx,
    output reg line_tx_oe,
    // stored configuration
    input wire [7:0] reply_dwell,
    input wire [3:0] startup_mode_setting,
    input wire [15:0] line_rate_setting,
    input wire [7:0] reply_format_options,
    // live drive conditions
    input wire [15:0] alarm_cond,
    // status
    output reg [15:0] alarm_word_q,
    output reg motor_disable_q,
    output reg status_fault_q,
    output reg text_mode_q,
    output reg comm_err_led_q,
    output reg saved_rate_q
);

    localparam M_ANN = 2'd0;
    localparam M_WAIT = 2'd1;
    localparam M_RUN = 2'd2;

    localparam [31:0] BIT_DEF_W = BIT_CYC_DEF;
    localparam [31:0] MS_LAST_W = MS_CYC - 1;
    localparam [15:0] BIT_DEF = BIT_DEF_W[15:0];
    localparam [23:0] MS_LAST = MS_LAST_W[23:0];

    // mode and startup
    reg [1:0] mode_q;
    reg pm_cap_q;
    reg pm_tool_q;
    reg zero_seen_q;

    // millisecond divider and timer
    reg [23:0] ms_cnt_q;
    reg [10:0] tmr_q;
    wire ms_tick;
    wire ms_restart;

    // command parser
    reg [7:0] c0_q;
    reg [7:0] c1_q;
    reg [1:0] ccnt_q;
    reg req_q;
    reg [1:0] req_kind_q;

    // comm error latch
    reg ce_latch_q;
    reg [3:0] ce_cause_q;

    // reply sequencer
    reg pkt_q;
    reg [1:0] kind_q;
    reg [3:0] idx_q;
    reg [3:0] len_q;
    reg [2:0] ndig_q;
    reg [15:0] snap_q;
    reg [7:0] dwell_left_q;
    reg ann_sent_q;
    reg pkt_done_q;
    reg tx_go_q;
    reg [7:0] tx_byte_q;

    wire [15:0] bit_div;
    wire rx_valid;
    wire [7:0] rx_data;
    wire frame_err;
    wire tx_busy;
    wire parse_ok;
    wire ce_clear;
    wire fmt_err_en;

    // announcement and wait run at default rate unless timed out
    assign bit_div = saved_rate_q ? line_rate_setting : BIT_DEF;

    assign ms_tick = (ms_cnt_q == MS_LAST);
    assign ms_restart = rx_valid || pkt_done_q;
    assign parse_ok = (mode_q == M_RUN) && text_mode_q;
    assign fmt_err_en = reply_format_options[`HLS_FMT_ERR_BIT];
    assign ce_clear = req_q && (req_kind_q == `HLS_K_CE);

    function [7:0] hex_char;
        input [3:0] v;
        begin
            hex_char = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
        end
    endfunction

    function [2:0] digit_count;
        input [15:0] w;
        begin
            if (w[15:12] != 4'h0)
                digit_count = 3'd4;
            else if (w[11:8] != 4'h0)
                digit_count = 3'd3;
            else if (w[7:4] != 4'h0)
                digit_count = 3'd2;
            else
                digit_count = 3'd1;
        end
    endfunction

    function [7:0] reply_byte;
        input [1:0] kind;
        input [2:0] idx;
        input [15:0] word;
        input [2:0] ndig;
        reg [2:0] pos;
        reg [3:0] nib;
        begin
            pos = ndig + 3'd2 - idx;
            case (pos[1:0])
                2'd0: nib = word[3:0];
                2'd1: nib = word[7:4];
                2'd2: nib = word[11:8];
                default: nib = word[15:12];
            endcase
            case (kind)
                `HLS_K_ANN:
                begin
                    if (idx == 3'd0)
                        reply_byte = `HLS_CH_ANN;
                    else if (idx == 3'd1)
                        reply_byte = FW_VERSION;
                    else
                        reply_byte = MODEL_CODE;
                end
                `HLS_K_ERR:
                begin
                    reply_byte = (idx == 3'd0) ? `HLS_CH_ERR : `HLS_CH_CR;
                end
                default:
                begin
                    if (idx == 3'd0)
                        reply_byte = (kind == `HLS_K_AL) ? `HLS_CH_A : `HLS_CH_C;
                    else if (idx == 3'd1)
                        reply_byte = (kind == `HLS_K_AL) ? `HLS_CH_L : `HLS_CH_E;
                    else if (idx == 3'd2)
                        reply_byte = `HLS_CH_EQ;
                    else if (idx == ndig + 3'd3)
                        reply_byte = `HLS_CH_CR;
                    else
                        reply_byte = hex_char(nib);
                end
            endcase
        end
    endfunction

    hls_uart_rx u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bit_div(bit_div),
        .line_rx(line_rx),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .frame_err(frame_err)
    );

    hls_uart_tx u_tx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bit_div(bit_div),
        .tx_start(tx_go_q),
        .tx_data(tx_byte_q),
        .tx_busy(tx_busy),
        .line_tx(line_tx)
    );

    // millisecond divider, realigned to each received character
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_cnt_q <= 24'h000000;
        else if (ms_restart || ms_tick)
            ms_cnt_q <= 24'h000000;
        else
            ms_cnt_q <= ms_cnt_q + 24'h000001;
    end

    // startup mode sampled once after reset release
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pm_cap_q <= 1'b0;
            pm_tool_q <= 1'b0;
        end
        else if (!pm_cap_q)
        begin
            pm_cap_q <= 1'b1;
            pm_tool_q <= (startup_mode_setting == `HLS_PM_TOOL_A) ||
                (startup_mode_setting == `HLS_PM_TOOL_B);
        end
    end

    // startup sequence and command parser
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= M_ANN;
            zero_seen_q <= 1'b0;
            tmr_q <= 11'h000;
            text_mode_q <= 1'b0;
            saved_rate_q <= 1'b0;
            c0_q <= 8'h00;
            c1_q <= 8'h00;
            ccnt_q <= 2'd0;
            req_q <= 1'b0;
            req_kind_q <= `HLS_K_AL;
        end
        else
        begin
            req_q <= 1'b0;
            case (mode_q)
                M_ANN:
                begin
                    tmr_q <= 11'h000;
                    if (pkt_done_q)
                        mode_q <= M_WAIT;
                end
                M_WAIT:
                begin
                    if (ms_tick)
                        tmr_q <= tmr_q + 11'h001;
                    if (rx_valid && rx_data == `HLS_CH_ZERO)
                    begin
                        zero_seen_q <= 1'b1;
                        if (zero_seen_q)
                        begin
                            // forced text mode, stored setting untouched
                            text_mode_q <= 1'b1;
                            mode_q <= M_RUN;
                        end
                    end
                    else if (rx_valid)
                    begin
                        zero_seen_q <= 1'b0;
                    end
                    else if (tmr_q == `HLS_ANN_WAIT_MS)
                    begin
                        saved_rate_q <= 1'b1;
                        text_mode_q <= ~pm_tool_q;
                        mode_q <= M_RUN;
                    end
                    tmr_q <= (tmr_q == `HLS_ANN_WAIT_MS) ? tmr_q :
                        tmr_q + {10'h000, ms_tick};
                end
                M_RUN:
                begin
                    if (rx_valid)
                        tmr_q <= 11'h000;
                    else if (ms_tick && ccnt_q != 2'd0)
                        tmr_q <= tmr_q + 11'h001;
                    if (parse_ok && rx_valid)
                    begin
                        if (rx_data == `HLS_CH_CR)
                        begin
                            ccnt_q <= 2'd0;
                            if (ccnt_q == 2'd2 && c0_q == `HLS_CH_A && c1_q == `HLS_CH_L)
                            begin
                                req_q <= ~pkt_q;
                                req_kind_q <= `HLS_K_AL;
                            end
                            else if (ccnt_q == 2'd2 && c0_q == `HLS_CH_C &&
                                c1_q == `HLS_CH_E)
                            begin
                                req_q <= ~pkt_q;
                                req_kind_q <= `HLS_K_CE;
                            end
                            else
                            begin
                                req_q <= fmt_err_en && ~pkt_q;
                                req_kind_q <= `HLS_K_ERR;
                            end
                        end
                        else
                        begin
                            if (ccnt_q == 2'd0)
                                c0_q <= rx_data;
                            if (ccnt_q == 2'd1)
                                c1_q <= rx_data;
                            if (ccnt_q != 2'd3)
                                ccnt_q <= ccnt_q + 2'd1;
                        end
                    end
                    else if (ccnt_q != 2'd0 && tmr_q == `HLS_CHAR_TO_MS)
                    begin
                        // stale partial command dropped
                        ccnt_q <= 2'd0;
                        req_q <= parse_ok && fmt_err_en && ~pkt_q;
                        req_kind_q <= `HLS_K_ERR;
                    end
                end
                default:
                begin
                    mode_q <= M_ANN;
                end
            endcase
        end
    end

    // hardware comm errors: latched silently, cleared by the query
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ce_latch_q <= 1'b0;
            ce_cause_q <= `HLS_CE_NONE;
        end
        else if (frame_err)
        begin
            ce_latch_q <= 1'b1;
            ce_cause_q <= `HLS_CE_FRAME;
        end
        else if (rx_valid && pkt_q)
        begin
            // character arriving while a reply occupies the line
            ce_latch_q <= 1'b1;
            ce_cause_q <= `HLS_CE_OVERRUN;
        end
        else if (ce_clear)
        begin
            ce_latch_q <= 1'b0;
        end
    end

    // alarm word and fault outputs
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_word_q <= 16'h0000;
            motor_disable_q <= 1'b0;
            status_fault_q <= 1'b0;
            comm_err_led_q <= 1'b0;
        end
        else
        begin
            alarm_word_q <= (alarm_cond & ~`HLS_AL_RSVD_MASK &
                ~(16'h0001 << `HLS_AL_COMM_BIT)) |
                ({15'h0000, ce_latch_q} << `HLS_AL_COMM_BIT);
            motor_disable_q <= |(alarm_word_q & `HLS_AL_FAULT_MASK);
            status_fault_q <= |(alarm_word_q & `HLS_AL_FAULT_MASK);
            comm_err_led_q <= ce_latch_q;
        end
    end

    // reply sequencer: dwell, then one character after another
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt_q <= 1'b0;
            kind_q <= `HLS_K_ANN;
            idx_q <= 4'd0;
            len_q <= 4'd0;
            ndig_q <= 3'd1;
            snap_q <= 16'h0000;
            dwell_left_q <= 8'h00;
            ann_sent_q <= 1'b0;
            pkt_done_q <= 1'b0;
            tx_go_q <= 1'b0;
            tx_byte_q <= 8'h00;
            line_tx_oe <= 1'b0;
        end
        else
        begin
            tx_go_q <= 1'b0;
            pkt_done_q <= 1'b0;
            if (pkt_q)
            begin
                if (dwell_left_q != 8'h00)
                begin
                    if (ms_tick)
                        dwell_left_q <= dwell_left_q - 8'h01;
                end
                else if (!tx_busy && !tx_go_q)
                begin
                    if (idx_q == len_q)
                    begin
                        pkt_q <= 1'b0;
                        pkt_done_q <= 1'b1;
                        line_tx_oe <= 1'b0;
                    end
                    else
                    begin
                        line_tx_oe <= 1'b1;
                        tx_go_q <= 1'b1;
                        tx_byte_q <= reply_byte(kind_q, idx_q[2:0], snap_q, ndig_q);
                        idx_q <= idx_q + 4'd1;
                    end
                end
            end
            else if (mode_q == M_ANN && !ann_sent_q)
            begin
                ann_sent_q <= 1'b1;
                pkt_q <= 1'b1;
                kind_q <= `HLS_K_ANN;
                idx_q <= 4'd0;
                len_q <= 4'd3;
                dwell_left_q <= 8'h00;
            end
            else if (req_q)
            begin
                pkt_q <= 1'b1;
                kind_q <= req_kind_q;
                idx_q <= 4'd0;
                dwell_left_q <= reply_dwell;
                if (req_kind_q == `HLS_K_AL)
                begin
                    snap_q <= alarm_word_q;
                    ndig_q <= digit_count(alarm_word_q);
                    len_q <= {1'b0, digit_count(alarm_word_q)} + 4'd4;
                end
                else if (req_kind_q == `HLS_K_CE)
                begin
                    snap_q <= {12'h000, ce_cause_q};
                    ndig_q <= 3'd1;
                    len_q <= 4'd5;
                end
                else
                begin
                    ndig_q <= 3'd1;
                    len_q <= 4'd2;
                end
            end
        end
    end

endmodule

/* core/hls_uart_rx.v */
module hls_uart_rx (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // bit period in clock cycles
    input wire [15:0] bit_div,
    // serial line
    input wire line_rx,
    // received character
    output reg rx_valid,
    output reg [7:0] rx_data,
    output reg frame_err
);

    localparam S_IDLE = 2'd0;
    localparam S_START = 2'd1;
    localparam S_DATA = 2'd2;
    localparam S_STOP = 2'd3;

    reg [1:0] state_q;
    reg [15:0] cnt_q;
    reg [2:0] nbit_q;
    reg [7:0] sh_q;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            cnt_q <= 16'h0000;
            nbit_q <= 3'h0;
            sh_q <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            frame_err <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            frame_err <= 1'b0;
            if (state_q != S_IDLE && cnt_q != 16'h0000)
            begin
                cnt_q <= cnt_q - 16'h0001;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        if (!line_rx)
                        begin
                            cnt_q <= {1'b0, bit_div[15:1]};
                            state_q <= S_START;
                        end
                    end
                    S_START:
                    begin
                        // a start bit gone high at mid-bit was a glitch
                        cnt_q <= bit_div - 16'h0001;
                        nbit_q <= 3'h0;
                        state_q <= line_rx ? S_IDLE : S_DATA;
                    end
                    S_DATA:
                    begin
                        sh_q <= {line_rx, sh_q[7:1]};
                        nbit_q <= nbit_q + 3'h1;
                        cnt_q <= bit_div - 16'h0001;
                        if (nbit_q == 3'h7)
                        begin
                            state_q <= S_STOP;
                        end
                    end
                    S_STOP:
                    begin
                        rx_data <= sh_q;
                        rx_valid <= line_rx;
                        frame_err <= ~line_rx;
                        state_q <= S_IDLE;
                    end
                    default:
                    begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* core/hls_uart_tx.v */
module hls_uart_tx (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // bit period in clock cycles
    input wire [15:0] bit_div,
    // character to send
    input wire tx_start,
    input wire [7:0] tx_data,
    output reg tx_busy,
    // serial line
    output reg line_tx
);

    reg [15:0] cnt_q;
    reg [3:0] nbit_q;
    reg [8:0] sh_q;
    wire bit_tick;

    // one-cycle pulse at the end of each bit period
    assign bit_tick = tx_busy && (cnt_q == bit_div - 16'h0001);

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 16'h0000;
            nbit_q <= 4'h0;
            sh_q <= 9'h1ff;
            tx_busy <= 1'b0;
            line_tx <= 1'b1;
        end
        else if (!tx_busy)
        begin
            cnt_q <= 16'h0000;
            if (tx_start)
            begin
                // start bit, then eight data bits lsb first, then stop
                line_tx <= 1'b0;
                sh_q <= {1'b1, tx_data};
                nbit_q <= 4'h0;
                tx_busy <= 1'b1;
            end
        end
        else if (bit_tick)
        begin
            cnt_q <= 16'h0000;
            if (nbit_q == 4'h9)
            begin
                tx_busy <= 1'b0;
            end
            else
            begin
                line_tx <= sh_q[0];
                sh_q <= {1'b1, sh_q[8:1]};
                nbit_q <= nbit_q + 4'h1;
            end
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule
